// >>> hdl/tsp_map.vh
// constants for the thermal scan and protect block
`ifndef TSP_MAP_VH
`define TSP_MAP_VH
`define TSP_CLK_MHZ 250
`define TSP_PERIOD_US 640000
`define TSP_ON_US 5000
`define TSP_SETTLE_US 1000
// cycle counts are sized so they meet the 28-bit counters exactly
`define TSP_PERIOD_CYC 28'h9896800
`define TSP_ON_CYC 28'h01312d0
`define TSP_SETTLE_CYC 28'h003d090
`define TSP_SEL_WIDTH 4
`define TSP_SEL_EXT_TEMP 4'h9
`define TSP_FLAGS_RESET 4'h0
`define TSP_CNT_WIDTH 28
`endif

// >>> hdl/tsp_sync.v
// two-flop synchroniser for the comparator input
`timescale 1ns/10ps
module tsp_sync (
    input wire i_ref_clk,
    input wire i_sys_rst,
    input wire i_clk_en,
    input wire i_d,
    output reg o_q
);
    reg meta;

    // first flop feeds only the second
    always @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            meta <= 1'b0;
            o_q <= 1'b0;
        end else if (i_clk_en) begin
            meta <= i_d;
            o_q <= meta;
        end
    end
endmodule

// >>> hdl/tsp_top.v
// thermistor bias scan and over-temperature switch protection
`timescale 1ns/10ps
`include "tsp_map.vh"
module tsp_top #(
    parameter [27:0] PERIOD_CYC = `TSP_PERIOD_CYC,
    parameter [27:0] ON_CYC = `TSP_ON_CYC,
    parameter [27:0] SETTLE_CYC = `TSP_SETTLE_CYC
) (
    input wire i_ref_clk,
    input wire i_sys_rst,
    input wire i_clk_en,
    input wire i_auto_scan_disable,
    input wire i_bias_force_on,
    input wire i_internal_overtemp_response_disable,
    input wire i_external_overtemp_response_disable,
    input wire [3:0] i_analog_select_field,
    input wire i_thermistor_sense_input,
    input wire i_internal_overtemp,
    input wire i_charge_overcurrent_flag,
    input wire i_discharge_overcurrent_flag,
    input wire i_short_circuit_flag,
    input wire i_switch_wr,
    input wire i_charge_switch_wdata,
    input wire i_discharge_switch_wdata,
    input wire i_flag_wr,
    input wire [3:0] i_user_flag_wdata,
    input wire i_por_request,
    output reg o_thermistor_bias_output,
    output reg [3:0] o_analog_monitor_select,
    output reg o_charge_switch_control,
    output reg o_discharge_switch_control,
    output reg o_internal_overtemp_flag,
    output reg o_external_overtemp_flag,
    output reg o_external_temp_fail,
    output reg o_overtemp_shutdown,
    output reg [3:0] o_user_flags
);
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_SETTLE = 3'b010;
    localparam [2:0] ST_WATCH = 3'b100;

    // notes for users of this block:
    // - the bias pin has three requesters: the periodic scan, the
    //   external select code and the force bit; they are or-ed, so
    //   the periodic scan never cuts a manual reading short
    // - the periodic window lags its counter wrap by two cycles,
    //   one for the window flop and one for the pin flop
    // - the settle tracker restarts on every bias drop, so a window
    //   shorter than the settle time never judges the comparator
    // - the comparator path adds two synchroniser cycles; the
    //   settle time must cover the divider and these two cycles,
    //   which it does by a wide margin at the default counts
    // - overtemp flags follow the condition and are not sticky;
    //   software that wants a history must read them while set
    // - the external flag keeps its last settled reading while
    //   the bias is off, so a shutdown caused by it can only end
    //   in a later settled window
    // - an automatic shutoff clears both switch controls; leaving
    //   shutdown does not restore them, software must write again
    // - overcurrent and short flags drive the bias pin high as a
    //   wake line; this also powers the divider, which is harmless
    //   but starts neither a settle period nor a reading
    // - the clock enable freezes every flop, the synchroniser too,
    //   so a frozen block resumes with its last sampled values
    // - user flags reset only on the reset input or a reset
    //   request; the request wins over a flag write in one cycle
    // - the select code for the external temperature is a local
    //   choice; all other codes only route the monitor selector

    reg [27:0] period_cnt;
    reg [27:0] settle_cnt;
    reg [2:0] state;
    reg [2:0] next_state;
    reg auto_on;
    wire sense_sync;
    wire ext_sel;
    wire bias_want;
    wire settled;
    wire ext_fail;
    wire int_trip;
    wire ext_trip;
    wire shut_now;

    tsp_sync u_sync (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_clk_en(i_clk_en),
        .i_d(i_thermistor_sense_input),
        .o_q(sense_sync)
    );

    assign ext_sel = (i_analog_select_field == `TSP_SEL_EXT_TEMP);
    // any of the three requesters keeps the divider powered
    assign bias_want = i_bias_force_on | ext_sel | auto_on;
    assign settled = (state == ST_WATCH);
    // sense below reference reads low from the comparator
    assign ext_fail = settled & ~sense_sync;
    assign int_trip = i_internal_overtemp &
        ~i_internal_overtemp_response_disable;
    assign ext_trip = ext_fail &
        ~i_external_overtemp_response_disable;
    assign shut_now = int_trip | ext_trip;

    // free-running period counter; auto window is its first ON_CYC
    always @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            period_cnt <= 28'h0000000;
            auto_on <= 1'b0;
        end else if (i_clk_en) begin
            if (period_cnt >= PERIOD_CYC - 28'h0000001)
                period_cnt <= 28'h0000000;
            else
                period_cnt <= period_cnt + 28'h0000001;
            // disable only stops the periodic window, not others
            auto_on <= ~i_auto_scan_disable &
                (period_cnt < ON_CYC);
        end
    end

    // settle tracker restarts whenever the bias goes off
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: if (bias_want) next_state = ST_SETTLE;
            ST_SETTLE: begin
                if (!bias_want)
                    next_state = ST_IDLE;
                else if (settle_cnt >= SETTLE_CYC - 28'h0000001)
                    next_state = ST_WATCH;
            end
            ST_WATCH: if (!bias_want) next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state <= ST_IDLE;
            settle_cnt <= 28'h0000000;
        end else if (i_clk_en) begin
            state <= next_state;
            if (state == ST_SETTLE)
                settle_cnt <= settle_cnt + 28'h0000001;
            else
                settle_cnt <= 28'h0000000;
        end
    end

    // bias pin: scan demand, or overcurrent wake signalling
    always @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_thermistor_bias_output <= 1'b0;
            o_analog_monitor_select <= 4'h0;
        end else if (i_clk_en) begin
            o_thermistor_bias_output <= bias_want |
                i_charge_overcurrent_flag |
                i_discharge_overcurrent_flag |
                i_short_circuit_flag;
            o_analog_monitor_select <= i_analog_select_field;
        end
    end

    // flags follow the condition; detection works even if disabled
    always @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_internal_overtemp_flag <= 1'b0;
            o_external_overtemp_flag <= 1'b0;
            o_external_temp_fail <= 1'b0;
        end else if (i_clk_en) begin
            o_internal_overtemp_flag <= i_internal_overtemp;
            o_external_temp_fail <= ext_fail;
            // external result only refreshed inside settled window
            if (settled)
                o_external_overtemp_flag <= ~sense_sync;
        end
    end

    // shutdown holds until internal overtemp and external flag are both clear
    always @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_overtemp_shutdown <= 1'b0;
            o_charge_switch_control <= 1'b0;
            o_discharge_switch_control <= 1'b0;
        end else if (i_clk_en) begin
            if (shut_now) begin
                o_overtemp_shutdown <= 1'b1;
                o_charge_switch_control <= 1'b0;
                o_discharge_switch_control <= 1'b0;
            end else if (o_overtemp_shutdown) begin
                // external clears only on a fresh settled reading
                if (~i_internal_overtemp & ~o_external_overtemp_flag)
                    o_overtemp_shutdown <= 1'b0;
                // writes during shutdown are dropped
            end else if (i_switch_wr) begin
                o_charge_switch_control <= i_charge_switch_wdata;
                o_discharge_switch_control <= i_discharge_switch_wdata;
            end
        end
    end

    // user flags freeze with the clock enable like every other flop; only reset or a request clears them
    always @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst)
            o_user_flags <= `TSP_FLAGS_RESET;
        else if (i_clk_en) begin
            if (i_por_request)
                o_user_flags <= `TSP_FLAGS_RESET;
            else if (i_flag_wr)
                o_user_flags <= i_user_flag_wdata;
        end
    end
endmodule

// >>> bench/tsp_pack_model.sv
// pack side thermistor divider and comparator model
`timescale 1ns/10ps
module tsp_pack_model (
    input wire i_ref_clk,
    input wire i_bias,
    input wire i_hot,
    output reg o_sense = 1'b1
);
    // unpowered divider floats: toggle so a stale level never passes
    always @(posedge i_ref_clk) begin
        o_sense <= i_bias ? !i_hot : !o_sense;
    end
endmodule

// >>> bench/tsp_top_assertions.sv
// checker on the thermal scan block ports
`timescale 1ns/10ps
module tsp_chk (
    input i_ref_clk, i_sys_rst, i_clk_en, i_bias_force_on,
    input i_internal_overtemp_response_disable, i_internal_overtemp,
    input [3:0] i_analog_select_field, i_user_flag_wdata,
    input i_charge_overcurrent_flag, i_discharge_overcurrent_flag,
    input i_short_circuit_flag, i_flag_wr, i_por_request,
    input o_thermistor_bias_output, o_charge_switch_control,
    input o_discharge_switch_control, o_external_temp_fail,
    input o_overtemp_shutdown,
    input [3:0] o_analog_monitor_select, o_user_flags
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    wire en = i_clk_en;
    wire bias = o_thermistor_bias_output;
    wire oc = i_charge_overcurrent_flag | i_discharge_overcurrent_flag;
    a_force_bias: assert property (en && i_bias_force_on |=> bias)
        else $error("bias low under force");
    a_select_bias: assert property (
        en && i_analog_select_field == 4'h9 |=> bias)
        else $error("bias low with external select");
    a_mon_route: assert property (
        en |=> o_analog_monitor_select == $past(i_analog_select_field))
        else $error("monitor select not routed");
    a_wake_bias: assert property (
        en && (oc || i_short_circuit_flag) |=> bias)
        else $error("bias low with overcurrent flag");
    a_flag_write: assert property (
        en && i_flag_wr && !i_por_request |=>
        o_user_flags == $past(i_user_flag_wdata))
        else $error("user flags not written");
    a_por_clear: assert property (
        en && i_por_request |=> o_user_flags == 4'h0)
        else $error("user flags not cleared");
    // a held shutdown must keep both switch controls off
    a_shut_clear: assert property (o_overtemp_shutdown |->
        !o_charge_switch_control && !o_discharge_switch_control)
        else $error("switch on during shutdown");
    a_int_trip: assert property (en && i_internal_overtemp &&
        !i_internal_overtemp_response_disable |-> ##[1:3] o_overtemp_shutdown)
        else $error("no shutdown on internal overtemp");
    a_fail_window: assert property (
        $rose(o_external_temp_fail) |-> $past(bias))
        else $error("fail flagged with bias off");
    cover property ($rose(o_overtemp_shutdown));
    cover property ($rose(o_external_temp_fail));
    cover property (i_por_request);
endmodule
bind tsp_top tsp_chk u_chk (.*);

// >>> bench/tsp_top_test.sv
// self-checking bench for the thermal scan and protect block
`timescale 1ns/10ps
module tsp_top_test;
    reg i_ref_clk = 1'b0, i_sys_rst = 1'b1, i_clk_en = 1'b1, hot = 1'b0;
    reg i_auto_scan_disable = 1'b0, i_bias_force_on = 1'b0;
    reg i_internal_overtemp_response_disable = 1'b0;
    reg i_external_overtemp_response_disable = 1'b0;
    reg [3:0] i_analog_select_field = 4'h0, i_user_flag_wdata = 4'h0;
    reg i_internal_overtemp = 1'b0, i_charge_overcurrent_flag = 1'b0;
    reg i_discharge_overcurrent_flag = 1'b0, i_short_circuit_flag = 1'b0;
    reg i_switch_wr = 1'b0, i_charge_switch_wdata = 1'b0;
    reg i_discharge_switch_wdata = 1'b0, i_flag_wr = 1'b0;
    reg i_por_request = 1'b0;
    wire i_thermistor_sense_input, o_thermistor_bias_output;
    wire o_charge_switch_control, o_discharge_switch_control;
    wire o_internal_overtemp_flag, o_external_overtemp_flag;
    wire o_external_temp_fail, o_overtemp_shutdown;
    wire [3:0] o_analog_monitor_select, o_user_flags;
    wire [1:0] sws = {o_charge_switch_control, o_discharge_switch_control};
    wire [3:0] obs = {o_thermistor_bias_output, o_overtemp_shutdown,
        o_external_overtemp_flag, o_internal_overtemp_flag};
    int errors = 0, total_checks = 0, i, n;
    // short counts keep the scan period to a few dozen cycles
    // settle of four covers bias flop, divider and two sync flops
    tsp_top #(.PERIOD_CYC(28'h40), .ON_CYC(28'h8), .SETTLE_CYC(28'h4))
        u_dut (.*);
    tsp_pack_model u_pack (.i_ref_clk(i_ref_clk),
        .i_bias(o_thermistor_bias_output), .i_hot(hot),
        .o_sense(i_thermistor_sense_input));
    initial forever #2 i_ref_clk = !i_ref_clk;
    task chk(input [7:0] seen, input [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task tk(input int c);
        repeat (c) @(posedge i_ref_clk);
        #1;
    endtask
    // bounded wait on one watched bit; running out ends the run
    task wt(input int b, input v);
        for (n = 0; n < 400 && obs[b] !== v; n++) tk(1);
        if (n == 400) begin
            chk(8'h0, 8'h1);
            report_and_stop;
        end
    endtask
    // one-cycle write pulse: 0 switches, 1 user flags, 2 reset request
    task pl(input int k, input [3:0] d);
        @(posedge i_ref_clk);
        {i_switch_wr, i_flag_wr, i_por_request} <= 3'h4 >> k;
        {i_charge_switch_wdata, i_discharge_switch_wdata} <= d[1:0];
        i_user_flag_wdata <= d;
        @(posedge i_ref_clk);
        {i_switch_wr, i_flag_wr, i_por_request} <= 3'h0;
        #1;
    endtask
    task ct;
        n = 0;
        repeat (140) begin
            n += (o_thermistor_bias_output !== 1'b0);
            tk(1);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        wt(3, 1);
        for (i = 0; o_thermistor_bias_output === 1'b1 && i < 99; i++) tk(1);
        chk(i[7:0], 8'h8);
        for (n = i; o_thermistor_bias_output === 1'b0 && n < 99; n++) tk(1);
        chk(n[7:0], 8'h40);
        @(posedge i_ref_clk) i_auto_scan_disable <= 1'b1;
        tk(12);
        ct;
        chk(n[7:0], 8'h0);
        @(posedge i_ref_clk) i_bias_force_on <= 1'b1;
        tk(2);
        ct;
        chk(n[7:0], 8'h8c);
        i_bias_force_on <= 1'b0;
        i_analog_select_field <= 4'h9;
        tk(2);
        ct;
        chk(n[7:0], 8'h8c);
        chk(o_analog_monitor_select, 8'h9);
        $display("scan modes done");
        pl(0, 4'h3);
        chk(sws, 8'h3);
        @(posedge i_ref_clk) hot <= 1'b1;
        wt(1, 1);
        chk(obs, 8'he);
        chk({sws, o_external_temp_fail}, 8'h1);
        pl(0, 4'h3);
        chk(sws, 8'h0);
        @(posedge i_ref_clk) hot <= 1'b0;
        wt(1, 0);
        chk(sws, 8'h0);
        pl(0, 4'h3);
        chk(sws, 8'h3);
        $display("external shutdown done");
        @(posedge i_ref_clk) i_internal_overtemp <= 1'b1;
        tk(2);
        chk(obs, 8'hd);
        chk(sws, 8'h0);
        @(posedge i_ref_clk) i_internal_overtemp <= 1'b0;
        tk(2);
        chk(obs, 8'h8);
        @(posedge i_ref_clk) i_internal_overtemp_response_disable <= 1'b1;
        i_internal_overtemp <= 1'b1;
        tk(2);
        chk(obs, 8'h9);
        pl(0, 4'h3);
        chk(sws, 8'h3);
        @(posedge i_ref_clk) i_internal_overtemp <= 1'b0;
        i_internal_overtemp_response_disable <= 1'b0;
        i_external_overtemp_response_disable <= 1'b1;
        hot <= 1'b1;
        wt(1, 1);
        chk(obs, 8'ha);
        chk(sws, 8'h3);
        @(posedge i_ref_clk) hot <= 1'b0;
        wt(1, 0);
        @(posedge i_ref_clk) i_external_overtemp_response_disable <= 1'b0;
        i_analog_select_field <= 4'h0;
        tk(3);
        chk(o_thermistor_bias_output, 8'h0);
        $display("internal and disable tests done");
        for (i = 0; i < 3; i++) begin
            @(posedge i_ref_clk);
            {i_charge_overcurrent_flag, i_discharge_overcurrent_flag,
                i_short_circuit_flag} <= 3'h4 >> i;
            tk(2);
            chk(o_thermistor_bias_output, 8'h1);
            {i_charge_overcurrent_flag, i_discharge_overcurrent_flag,
                i_short_circuit_flag} <= 3'h0;
            tk(2);
            chk(o_thermistor_bias_output, 8'h0);
        end
        $display("wake signalling done");
        pl(1, 4'ha);
        chk(o_user_flags, 8'ha);
        @(posedge i_ref_clk) i_clk_en <= 1'b0;
        pl(1, 4'h5);
        tk(3);
        chk(o_user_flags, 8'ha);
        @(posedge i_ref_clk) i_clk_en <= 1'b1;
        pl(2, 4'h0);
        chk(o_user_flags, 8'h0);
        pl(1, 4'h6);
        chk(o_user_flags, 8'h6);
        @(posedge i_ref_clk) i_sys_rst <= 1'b1;
        tk(2);
        i_sys_rst <= 1'b0;
        tk(2);
        chk({obs, sws, o_user_flags}, 8'h0);
        $display("user flags and reset done");
        report_and_stop;
    end
endmodule
